/* File: hsw_pkg.sv */
package hsw_pkg;
  localparam logic [7:0] WR_ADDR_LO    = 8'h76;
  localparam logic [7:0] WR_ADDR_HI    = 8'h78;
  localparam logic [7:0] DEVICE_ID     = 8'h5A; // Arbitrary value
  localparam logic [7:0] REG_ID        = 8'h01;
  localparam logic [7:0] REG_MODE      = 8'h02;
  localparam logic [7:0] REG_PERSW     = 8'h03;
  localparam logic [7:0] REG_CONTROL_THREE_REG     = 8'h04;
  localparam logic [7:0] REG_RESULT    = 8'h05;
  localparam logic [7:0] REG_INT       = 8'h06;
  localparam logic [7:0] REG_INTMASK   = 8'h07;
  localparam logic [7:0] WMASK_MODE    = 8'h0F;
  localparam logic [7:0] WMASK_PERSW   = 8'hF3;
  localparam logic [7:0] WMASK_CONTROL_THREE_REG   = 8'h1E;
  localparam logic [7:0] WMASK_INTMASK = 8'h1B;
  localparam logic [7:0] INT_BITS      = 8'h0B;
  localparam int         C3_KICK       = 0;
  localparam int         C3_INHIBIT    = 1;
  localparam int         C3_IRQSEL     = 2;
  localparam int         C3_TRIGDIS    = 3;
  localparam int         C3_FORCELOW   = 4;
  localparam int         BBM_BIT       = 3;
  localparam int         CMD_BURST     = 7;
  localparam int         INT_DONE      = 0;
  localparam int         INT_MIC       = 1;
  localparam int         INT_ERR       = 3;
  localparam int         MASK_PIN_OFF  = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int         SW_W          = 6;
  localparam logic [2:0] MODE_ISO      = 3'h0;
  localparam logic [2:0] MODE_RSVD     = 3'h1;
  localparam logic [2:0] MODE_NSE      = 3'h2;
  localparam logic [2:0] MODE_RSE      = 3'h3;
  localparam logic [2:0] MODE_NDIFF    = 3'h4;
  localparam logic [2:0] MODE_RDIFF    = 3'h5;
  localparam logic [2:0] MODE_PRONG3   = 3'h6;
  localparam logic [2:0] MODE_MANUAL   = 3'h7;
  // Switch vector order {s1nr, s1ns, s1pr, s1ps, fet1, fet2}
  localparam logic [5:0] SW_NSE        = 6'h26;
  localparam logic [5:0] SW_RSE        = 6'h19;
  localparam logic [5:0] SW_NDIFF      = 6'h24;
  localparam logic [5:0] SW_RDIFF      = 6'h18;
  localparam logic [5:0] SW_PRONG3     = 6'h33;
endpackage : hsw_pkg

/* File: hsw_sig_if.sv */
`timescale 1ns/100ps
interface hsw_sig_if;
  import hsw_pkg::*;
  logic            sclRise;
  logic            sclFall;
  logic            startCond;
  logic            stopCond;
  logic            sdaNow;
  logic [2:0]      mode;
  logic            bbm;
  logic [SW_W-1:0] manualSw;
  logic [SW_W-1:0] sw;
  modport edge_src (output sclRise, sclFall, startCond, stopCond, sdaNow);
  modport edge_snk (input sclRise, sclFall, startCond, stopCond, sdaNow);
  modport sw_ctl   (output mode, bbm, manualSw, input sw);
  modport sw_drv   (input mode, bbm, manualSw, output sw);
endinterface : hsw_sig_if

/* File: hsw_bus_edges.sv */
`timescale 1ns/100ps
module hsw_bus_edges
  import hsw_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic scl,
  input  wire logic sda,
  hsw_sig_if.edge_src bus
);
  typedef struct packed {
    logic scl;
    logic sda;
  } hsw_edge_t;
  hsw_edge_t q;
  hsw_edge_t n;
  always_comb begin
    n.scl = scl;
    n.sda = sda;
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q <= '1; // Idle bus is high
    end else begin
      q <= n;
    end
  end
  assign bus.sclRise   = scl & ~q.scl;
  assign bus.sclFall   = ~scl & q.scl;
  assign bus.startCond = scl & q.scl & q.sda & ~sda;
  assign bus.stopCond  = scl & q.scl & ~q.sda & sda;
  assign bus.sdaNow    = sda;
endmodule : hsw_bus_edges

/* File: hsw_switch_ctl.sv */
`timescale 1ns/100ps
module hsw_switch_ctl
  import hsw_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  hsw_sig_if.sw_drv sig
);
  typedef struct packed {
    logic [SW_W-1:0] sw;
  } hsw_sw_t;
  hsw_sw_t         q;
  hsw_sw_t         n;
  logic [SW_W-1:0] want;
  always_comb begin
    unique case (sig.mode)
      MODE_ISO, MODE_RSVD: want = '0;
      MODE_NSE:            want = SW_NSE;
      MODE_RSE:            want = SW_RSE;
      MODE_NDIFF:          want = SW_NDIFF;
      MODE_RDIFF:          want = SW_RDIFF;
      MODE_PRONG3:         want = SW_PRONG3;
      MODE_MANUAL:         want = sig.manualSw;
    endcase
    n = q;
    // Open everything for one cycle before a new set closes
    if (sig.bbm && want != q.sw && q.sw != '0) begin
      n.sw = '0;
    end else begin
      n.sw = want;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign sig.sw = q.sw;
endmodule : hsw_switch_ctl

/* File: hsw_i2c_ctrl.sv */
`timescale 1ns/100ps
module hsw_i2c_ctrl
  import hsw_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            srst,
  input  wire logic            scl,
  input  wire logic            sdaIn,
  output wire logic            sdaOut,
  output wire logic            sdaOeN,
  input  wire logic            addrSel,
  input  wire logic            kickPin,
  output wire logic            micPresentNOut,
  output wire logic            micPresentNOeN,
  output wire logic            detStart,
  input  wire logic            detDone,
  input  wire logic [7:0]      detResult,
  input  wire logic            micFound,
  input  wire logic            micOnSleeve,
  input  wire logic            detError,
  output wire logic [SW_W-1:0] switchState
);
  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ACK_ADDR,
    S_RX,
    S_ACK_RX,
    S_TX,
    S_MACK
  } hsw_state_t;

  typedef struct packed {
    hsw_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic       cmdPending;
    logic       rw;
    logic       burst;
    logic       mAck;
    logic       sdaLow;
    logic       kickPrev;
    logic       detStart;
    logic       pinLow;
    logic       micLevel;
    logic [7:0] modeReg;
    logic [7:0] perSwReg;
    logic [7:0] ctrl3Reg;
    logic [7:0] resultReg;
    logic [7:0] intReg;
    logic [7:0] intMaskReg;
  } hsw_main_t;

  hsw_main_t  q;
  hsw_main_t  n;
  hsw_sig_if  sig ();
  logic [7:0] ownAddr;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  logic [7:0] wrData;
  logic       intPending;
  logic       indicatorOn;

  hsw_bus_edges u_edges (
    .sys_clk (sys_clk),
    .srst    (srst),
    .scl     (scl),
    .sda     (sdaIn),
    .bus     (sig)
  );

  hsw_switch_ctl u_switch (
    .sys_clk (sys_clk),
    .srst    (srst),
    .sig     (sig)
  );

  function automatic logic [7:0] rdReg(input hsw_main_t s, input logic [7:0] a);
    case (a)
      REG_ID:      rdReg = DEVICE_ID;
      REG_MODE:    rdReg = s.modeReg;
      REG_PERSW:   rdReg = s.perSwReg;
      REG_CONTROL_THREE_REG:   rdReg = s.ctrl3Reg;
      REG_RESULT:  rdReg = s.resultReg;
      REG_INT:     rdReg = s.intReg;
      REG_INTMASK: rdReg = s.intMaskReg;
      default:     rdReg = 8'h00;
    endcase
  endfunction : rdReg

  assign ownAddr = addrSel ? WR_ADDR_HI : WR_ADDR_LO;
  // Burst read takes the next register once the master acks
  assign rdAddr  = (q.state == S_MACK && q.burst) ? q.ptr + 8'h01 : q.ptr;
  assign rdData  = rdReg(q, rdAddr);
  assign wrData  = q.shift;
  assign intPending = |(q.intReg & ~q.intMaskReg & INT_BITS);

  always_comb begin
    n = q;
    n.detStart = 1'b0;
    n.kickPrev = kickPin;

    unique case (q.state)
      S_IDLE: begin
        n.sdaLow = 1'b0;
      end
      S_ADDR, S_RX: begin
        if (sig.sclRise) begin
          n.shift  = {q.shift[6:0], sig.sdaNow};
          n.bitCnt = q.bitCnt + 4'h1;
        end else if (sig.sclFall && q.bitCnt == BITS_PER_BYTE) begin
          n.bitCnt = '0;
          if (q.state == S_RX) begin
            n.sdaLow = 1'b1;
            n.state  = S_ACK_RX;
          end else if (q.shift[7:1] == ownAddr[7:1]) begin
            // General call never equals either own address
            n.rw     = q.shift[0];
            n.sdaLow = 1'b1;
            n.state  = S_ACK_ADDR;
          end else begin
            n.state = S_IDLE;
          end
        end
      end
      S_ACK_ADDR: begin
        if (sig.sclRise && q.rw) begin
          n.shift = rdData;
          if (rdAddr == REG_INT) begin
            n.intReg = '0;
          end
        end else if (sig.sclFall) begin
          if (q.rw) begin
            n.sdaLow = ~q.shift[7];
            n.bitCnt = 4'h1;
            n.state  = S_TX;
          end else begin
            n.sdaLow     = 1'b0;
            n.cmdPending = 1'b1;
            n.state      = S_RX;
          end
        end
      end
      S_ACK_RX: begin
        if (sig.sclRise) begin
          if (q.cmdPending) begin
            n.cmdPending = 1'b0;
            n.ptr        = {1'b0, wrData[6:0]};
            n.burst      = wrData[CMD_BURST];
          end else begin
            // Read-only targets take the ack but keep their value
            case (q.ptr)
              REG_MODE:    n.modeReg    = wrData & WMASK_MODE;
              REG_PERSW:   n.perSwReg   = wrData & WMASK_PERSW;
              REG_INTMASK: n.intMaskReg = wrData & WMASK_INTMASK;
              REG_CONTROL_THREE_REG: begin
                n.ctrl3Reg = wrData & WMASK_CONTROL_THREE_REG;
                n.detStart = wrData[C3_KICK];
              end
              default: begin
              end
            endcase
            if (q.burst) begin
              n.ptr = q.ptr + 8'h01;
            end
          end
        end else if (sig.sclFall) begin
          n.sdaLow = 1'b0;
          n.state  = S_RX;
        end
      end
      S_TX: begin
        if (sig.sclFall) begin
          if (q.bitCnt == BITS_PER_BYTE) begin
            n.sdaLow = 1'b0;
            n.state  = S_MACK;
          end else begin
            n.shift  = {q.shift[6:0], 1'b0};
            n.sdaLow = ~q.shift[6];
            n.bitCnt = q.bitCnt + 4'h1;
          end
        end
      end
      S_MACK: begin
        if (sig.sclRise) begin
          n.mAck = ~sig.sdaNow;
          if (!sig.sdaNow) begin
            n.ptr   = rdAddr;
            n.shift = rdData;
            if (rdAddr == REG_INT) begin
              n.intReg = '0;
            end
          end else begin
            n.state = S_IDLE;
          end
        end else if (sig.sclFall && q.mAck) begin
          n.sdaLow = ~q.shift[7];
          n.bitCnt = 4'h1;
          n.state  = S_TX;
        end
      end
      // Unused state code falls back to idle
      default: begin
        n.state  = S_IDLE;
        n.sdaLow = 1'b0;
      end
    endcase

    // Bus conditions override any byte in flight
    if (sig.stopCond) begin
      n.state  = S_IDLE;
      n.sdaLow = 1'b0;
    end else if (sig.startCond) begin
      n.state      = S_ADDR;
      n.bitCnt     = '0;
      n.sdaLow     = 1'b0;
      n.cmdPending = 1'b0;
    end

    if (kickPin && !q.kickPrev && !q.ctrl3Reg[C3_TRIGDIS]) begin
      n.detStart = 1'b1;
    end

    // Placed after the read clear so a new event survives it
    if (detDone) begin
      n.resultReg         = detResult;
      n.micLevel          = micFound;
      n.intReg[INT_DONE]  = 1'b1;
      if (micFound) begin
        n.intReg[INT_MIC] = 1'b1;
      end
      if (detError) begin
        n.intReg[INT_ERR] = 1'b1;
      end
      if (!q.ctrl3Reg[C3_INHIBIT]) begin
        // Polarity picks the single-ended orientation
        if (!micFound) begin
          n.modeReg[2:0] = MODE_PRONG3;
        end else if (micOnSleeve) begin
          n.modeReg[2:0] = MODE_NSE;
        end else begin
          n.modeReg[2:0] = MODE_RSE;
        end
      end
    end

    n.pinLow = indicatorOn;
  end

  always_comb begin
    if (q.intMaskReg[MASK_PIN_OFF]) begin
      indicatorOn = 1'b0;
    end else if (q.ctrl3Reg[C3_IRQSEL]) begin
      indicatorOn = intPending;
    end else begin
      indicatorOn = q.micLevel;
    end
    if (q.ctrl3Reg[C3_FORCELOW]) begin
      indicatorOn = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign sig.mode       = q.modeReg[2:0];
  assign sig.bbm        = q.modeReg[BBM_BIT];
  assign sig.manualSw   = {q.perSwReg[7:4], q.perSwReg[1:0]};
  assign switchState    = sig.sw;
  assign sdaOut         = 1'b0;
  assign sdaOeN         = ~q.sdaLow;
  assign micPresentNOut = 1'b0;
  assign micPresentNOeN = ~q.pinLow;
  assign detStart       = q.detStart;
endmodule : hsw_i2c_ctrl

/* File: hsw_ctrl_properties.sv */
`timescale 1ns/100ps
module hsw_ctrl_properties
  import hsw_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            srst,
  input wire logic            scl,
  input wire logic            sdaIn,
  input wire logic            sdaOut,
  input wire logic            sdaOeN,
  input wire logic            micPresentNOut,
  input wire logic            micPresentNOeN,
  input wire logic            detStart,
  input wire logic            detDone,
  input wire logic [SW_W-1:0] switchState
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  chk_reset_idle:
    assert property (disable iff (1'b0) srst |=> sdaOeN && micPresentNOeN && !detStart
      && switchState == '0) else $error("outputs not idle after reset");
  chk_pins_open_drain:
    assert property (sdaOut == 1'b0 && micPresentNOut == 1'b0)
      else $error("open drain data not low");
  chk_sda_change_low:
    assert property ($changed(sdaOeN) |-> !scl && $past(!scl))
      else $error("sda drive changed near scl high");
  chk_sda_hold_high:
    assert property ($rose(scl) |-> ##1 $stable(sdaOeN) [*3])
      else $error("sda drive moved in scl high phase");
  chk_ack_stands:
    assert property ($fell(sdaOeN) |=> !sdaOeN [*4])
      else $error("sda drive too short");
  chk_start_pulse:
    assert property (detStart |=> !detStart)
      else $error("detection request longer than one cycle");
  chk_switch_cause:
    assert property ($changed(switchState) |-> !sdaIn || $past(detDone, 2)
      || $past(detDone, 3)) else $error("switches moved without cause");
  chk_indicator_cause:
    assert property ($changed(micPresentNOeN) |-> !sdaIn || $past(sdaIn == 1'b0)
      || $past(detDone, 2)) else $error("indicator moved without cause");
endmodule : hsw_ctrl_properties
bind hsw_i2c_ctrl hsw_ctrl_properties i_props (.sys_clk, .srst, .scl, .sdaIn, .sdaOut,
  .sdaOeN, .micPresentNOut, .micPresentNOeN, .detStart, .detDone, .switchState);

/* File: hsw_i2c_master_model.sv */
`timescale 1ns/100ps
module hsw_i2c_master_model (
  input  wire logic sys_clk,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaPull
);
  localparam int HALF = 5;
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic waitCyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : waitCyc
  // Serves as repeated start too
  task automatic startCond();
    sdaPull <= 1'b0;
    waitCyc(HALF);
    scl <= 1'b1;
    waitCyc(HALF);
    sdaPull <= 1'b1;
    waitCyc(HALF);
    scl <= 1'b0;
    waitCyc(HALF);
  endtask : startCond
  task automatic stopCond();
    sdaPull <= 1'b1;
    waitCyc(HALF);
    scl <= 1'b1;
    waitCyc(HALF);
    sdaPull <= 1'b0;
    waitCyc(HALF);
  endtask : stopCond
  task automatic clockBit(input logic b, output logic seen);
    sdaPull <= !b;
    waitCyc(HALF);
    scl <= 1'b1;
    waitCyc(HALF);
    seen = sdaWire;
    scl <= 1'b0;
    waitCyc(HALF);
  endtask : clockBit
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clockBit(d[i], s);
    clockBit(1'b1, s);
    ack = !s;
  endtask : sendByte
  task automatic recvByte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clockBit(1'b1, s);
      d[i] = s;
    end
    clockBit(!ack, s);
  endtask : recvByte
endmodule : hsw_i2c_master_model

/* File: hsw_i2c_ctrl_bench.sv */
`timescale 1ns/100ps
module hsw_i2c_ctrl_bench;
  import hsw_pkg::*;
  logic        sys_clk, srst, sdaPull, addrSel, kickPin;
  logic        detDone, micFound, micOnSleeve, detError;
  logic [7:0]  detResult, r;
  logic        scl, sdaOut, sdaOeN, micPresentNOut, micPresentNOeN, detStart;
  logic [5:0]  switchState;
  logic [7:0]  bytesQ [$];
  logic [7:0]  expQ [$];
  logic [31:0] lfsr = 32'h930624DF;
  int          error_cnt, n_compared, startCnt, n0;
  wire         sdaWire = !(sdaPull || !sdaOeN);
  hsw_i2c_master_model i_master (.sys_clk(sys_clk), .sdaWire(sdaWire), .scl(scl),
    .sdaPull(sdaPull));
  hsw_i2c_ctrl i_hsw_i2c_ctrl (.sys_clk(sys_clk), .srst(srst), .scl(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .addrSel(addrSel), .kickPin(kickPin),
    .micPresentNOut(micPresentNOut), .micPresentNOeN(micPresentNOeN), .detStart(detStart),
    .detDone(detDone), .detResult(detResult), .micFound(micFound),
    .micOnSleeve(micOnSleeve), .detError(detError), .switchState(switchState));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = !sys_clk;
  end
  always @(posedge sys_clk) begin
    if (detStart === 1'b1) startCnt <= startCnt + 1;
  end
  function automatic logic [31:0] nextRnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRnd
  function automatic logic [5:0] modeSw(input logic [2:0] m, input logic [7:0] per);
    case (m)
      3'h2: return 6'h26;
      3'h3: return 6'h19;
      3'h4: return 6'h24;
      3'h5: return 6'h18;
      3'h6: return 6'h33;
      3'h7: return {per[7:4], per[1:0]};
      default: return 6'h00;
    endcase
  endfunction : modeSw
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic probe(input logic [7:0] a, input logic exp);
    logic k;
    i_master.startCond();
    i_master.sendByte(a, k);
    check("addr ack", {7'h0, k}, {7'h0, exp});
    i_master.stopCond();
  endtask : probe
  // Writes bytesQ, or reads n bytes into it
  task automatic xfer(input logic [7:0] cmd, input bit rd, input bit split, input int n);
    logic       k;
    logic [7:0] d;
    logic [7:0] wa;
    wa = addrSel ? WR_ADDR_HI : WR_ADDR_LO;
    i_master.startCond();
    if (!split) begin
      i_master.sendByte(wa, k);
      check("addr ack", {7'h0, k}, 8'h01);
      i_master.sendByte(cmd, k);
      check("cmd ack", {7'h0, k}, 8'h01);
    end
    if (rd) begin
      if (!split) i_master.startCond();
      i_master.sendByte(wa | 8'h01, k);
      check("read ack", {7'h0, k}, 8'h01);
      bytesQ = {};
      for (int i = 0; i < n; i++) begin
        i_master.recvByte(i < n - 1, d);
        bytesQ.push_back(d);
      end
    end else begin
      foreach (bytesQ[i]) begin
        i_master.sendByte(bytesQ[i], k);
        check("data ack", {7'h0, k}, 8'h01);
      end
    end
    i_master.stopCond();
  endtask : xfer
  task automatic detect(input logic mic, input logic sl, input logic [7:0] res, input logic e);
    detDone <= 1'b1;
    micFound <= mic;
    micOnSleeve <= sl;
    detResult <= res;
    detError <= e;
    @(posedge sys_clk);
    detDone <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : detect
  initial begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end
  initial begin
    {srst, addrSel, kickPin, detDone, micFound, micOnSleeve, detError} <= 7'h40;
    detResult <= 8'h00;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    check("sw reset", {2'b00, switchState}, 8'h00);
    xfer(REG_ID, 1, 0, 2);
    foreach (bytesQ[i]) check("id", bytesQ[i], DEVICE_ID);
    probe(8'h00, 1'b0);
    probe(8'h78, 1'b0);
    repeat (4) begin
      lfsr = nextRnd(lfsr);
      r = lfsr[7:0];
      bytesQ = '{8'h07, r, 8'h00, 8'hFF, 8'hFF, 8'h00};
      xfer(8'h82, 0, 0, 0);
      check("manual sw", {2'b00, switchState}, {2'b00, modeSw(3'h7, r)});
      xfer(8'h82, 1, 0, 6);
      expQ = '{8'h07, r & 8'hF3, 8'h00, 8'h00, 8'h00, 8'h00};
      foreach (expQ[i]) check("burst", bytesQ[i], expQ[i]);
    end
    bytesQ = '{~r};
    xfer(REG_PERSW, 0, 0, 0);
    xfer(8'h00, 1, 1, 2);
    foreach (bytesQ[i]) check("split", bytesQ[i], ~r & 8'hF3);
    for (int m = 0; m < 7; m++) begin
      bytesQ = '{8'(m)};
      if (m != 1) xfer(REG_MODE, 0, 0, 0);
      check("preset", {2'b00, switchState}, {2'b00, modeSw(m[2:0], 8'h00)});
    end
    for (int k = 0; k < 3; k++) begin
      lfsr = nextRnd(lfsr);
      detect(k != 2, lfsr[0], lfsr[15:8], 1'b0);
      r = {5'h0, k == 2 ? 3'h6 : {2'b01, !lfsr[0]}};
      check("auto sw", {2'b00, switchState}, {2'b00, modeSw(r[2:0], 8'h00)});
      check("indicator", {7'h0, micPresentNOeN}, {7'h0, k == 2});
      xfer(REG_RESULT, 1, 0, 1);
      check("result", bytesQ[0], lfsr[15:8]);
    end
    bytesQ = '{8'h0A};
    xfer(REG_MODE, 0, 0, 0);
    bytesQ = '{8'h0B};
    xfer(REG_MODE, 0, 0, 0);
    check("bbm sw", {2'b00, switchState}, {2'b00, modeSw(3'h3, 8'h00)});
    bytesQ = '{8'h00, 8'h00, 8'h06};
    xfer(8'h82, 0, 0, 0);
    n0 = startCnt;
    kickPin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    kickPin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("kick pin", 8'(startCnt - n0), 8'h01);
    detect(1'b1, 1'b1, 8'h5C, 1'b1);
    check("inhibit sw", {2'b00, switchState}, 8'h00);
    check("irq low", {7'h0, micPresentNOeN}, 8'h00);
    xfer(REG_INT, 1, 0, 1);
    check("int", bytesQ[0], 8'h0B);
    check("irq clear", {7'h0, micPresentNOeN}, 8'h01);
    xfer(REG_MODE, 1, 0, 1);
    check("mode kept", bytesQ[0], 8'h00);
    bytesQ = '{8'h07};
    xfer(REG_CONTROL_THREE_REG, 0, 0, 0);
    check("kick reg", 8'(startCnt - n0), 8'h02);
    xfer(REG_CONTROL_THREE_REG, 1, 0, 1);
    check("kick clear", bytesQ[0], 8'h06);
    bytesQ = '{8'h16};
    xfer(REG_CONTROL_THREE_REG, 0, 0, 0);
    check("force low", {7'h0, micPresentNOeN}, 8'h00);
    addrSel <= 1'b1;
    @(posedge sys_clk);
    probe(8'h76, 1'b0);
    bytesQ = '{8'h1B};
    xfer(REG_INTMASK, 0, 0, 0);
    xfer(REG_INTMASK, 1, 0, 1);
    check("alt addr", bytesQ[0], 8'h1B);
    conclude();
  end
endmodule : hsw_i2c_ctrl_bench
